// [include/psc_pkg.sv]
// Shared constants and types for the power switch state controller
package psc_pkg;

  // Timing: figures in their own unit, counts derived from the clock rate
  localparam longint unsigned PSC_CLK_HZ       = 200_000_000;
  localparam longint unsigned PSC_LONG_PRESS_S = 4;
  localparam longint unsigned PSC_DEBOUNCE_MS  = 10;
  localparam longint unsigned PSC_LONG_CYC     = PSC_LONG_PRESS_S * PSC_CLK_HZ;
  localparam longint unsigned PSC_DEB_CYC      = (PSC_DEBOUNCE_MS * PSC_CLK_HZ + 999) / 1000;

  // Sleep type requested by the operating system or the button setting
  localparam logic [1:0] PSC_SLP_S1 = 2'h0;
  localparam logic [1:0] PSC_SLP_S3 = 2'h1;
  localparam logic [1:0] PSC_SLP_S4 = 2'h2;

  // Reported sleeping-state codes
  localparam logic [2:0] PSC_SCODE_S0 = 3'h0;
  localparam logic [2:0] PSC_SCODE_S1 = 3'h1;
  localparam logic [2:0] PSC_SCODE_S3 = 3'h3;
  localparam logic [2:0] PSC_SCODE_S4 = 3'h4;
  localparam logic [2:0] PSC_SCODE_S5 = 3'h5;

  // Reported global-state codes
  localparam logic [1:0] PSC_GCODE_G0 = 2'h0;
  localparam logic [1:0] PSC_GCODE_G1 = 2'h1;
  localparam logic [1:0] PSC_GCODE_G2 = 2'h2;

  // Rail bit positions in the packed rail word
  localparam int PSC_RAIL_CPU_RUN = 3;
  localparam int PSC_RAIL_CPU_PWR = 2;
  localparam int PSC_RAIL_DEV_PWR = 1;
  localparam int PSC_RAIL_RAM     = 0;

  typedef enum logic [2:0] {
    PSC_ST_S0,
    PSC_ST_S1,
    PSC_ST_S3,
    PSC_ST_S4,
    PSC_ST_S5
  } psc_state_type;

  typedef struct packed {
    psc_state_type st;
    logic [3:0]    rails;
    logic [2:0]    scode;
    logic [1:0]    gcode;
    logic          cold_boot;
    logic          resume;
    logic          disk_restore;
    logic          intrusion;
  } psc_top_st_type;

endpackage : psc_pkg

// [include/psc_sw_if.sv]
// Carrier between the switch timer and the state controller
`timescale 1ns/1ps
interface psc_sw_if;
  logic pressed;
  logic short_pulse;
  logic long_pulse;

  modport timer (output pressed, output short_pulse, output long_pulse);
  modport ctrl  (input pressed, input short_pulse, input long_pulse);
endinterface : psc_sw_if

// [design/psc_sw_timer.sv]
// Power switch debouncer and press duration timer
`timescale 1ns/1ps
module psc_sw_timer
  import psc_pkg::*;
#(
  parameter longint unsigned DEB_CYC  = PSC_DEB_CYC,
  parameter longint unsigned LONG_CYC = PSC_LONG_CYC
) (
  // Clock, reset, enable
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // Raw switch level, high while pressed
  input  wire logic sw_raw_in,
  // Cleaned switch events
  psc_sw_if.timer   sw
);

  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int LW = $clog2(LONG_CYC + 1);

  // Refused at elaboration: the window must close before a long press can
  if (DEB_CYC < 1 || LONG_CYC <= DEB_CYC) begin : g_bad_counts
    $error("psc_sw_timer: need 1 <= DEB_CYC < LONG_CYC");
  end

  typedef struct packed {
    logic          stable;
    logic [DW-1:0] deb_cnt;
    logic [LW-1:0] hold_cnt;
    logic          long_done;
    logic          short_p;
    logic          long_p;
  } psc_deb_st_type;

  psc_deb_st_type r_q;
  psc_deb_st_type r_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d         = r_q;
    r_d.short_p = 1'b0;
    r_d.long_p  = 1'b0;
    // A level must hold for the whole window before it is believed
    if (sw_raw_in != r_q.stable) begin
      if (r_q.deb_cnt == DW'(DEB_CYC - 1)) begin
        r_d.stable  = sw_raw_in;
        r_d.deb_cnt = '0;
        // A release on the long-press edge counts as long, not short
        if (!sw_raw_in && !r_q.long_done && r_q.hold_cnt != LW'(LONG_CYC - 1)) begin
          r_d.short_p = 1'b1;
        end
      end else begin
        r_d.deb_cnt = r_q.deb_cnt + DW'(1);
      end
    end else begin
      r_d.deb_cnt = '0;
    end
    // Long press fires while still held, once per press
    if (r_q.stable) begin
      if (r_q.hold_cnt == LW'(LONG_CYC - 1) && !r_q.long_done) begin
        r_d.long_p    = 1'b1;
        r_d.long_done = 1'b1;
      end else if (!r_q.long_done) begin
        r_d.hold_cnt = r_q.hold_cnt + LW'(1);
      end
    end else begin
      r_d.hold_cnt  = '0;
      r_d.long_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_q <= '0;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

  assign sw.pressed     = r_q.stable;
  assign sw.short_pulse = r_q.short_p;
  assign sw.long_pulse  = r_q.long_p;

endmodule : psc_sw_timer

// [design/psc_top.sv]
// Power switch state controller: global and sleeping state sequencing
`timescale 1ns/1ps
module psc_top
  import psc_pkg::*;
#(
  parameter longint unsigned DEB_CYC  = PSC_DEB_CYC,
  parameter longint unsigned LONG_CYC = PSC_LONG_CYC
) (
  // Clock, reset, enable
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  // Front panel and chassis switches
  input  wire logic       pwr_sw_pressed_in,
  input  wire logic       chassis_sw_closed_in,
  input  wire logic       intrusion_clr_in,
  // Operating system commands
  input  wire logic [1:0] sleep_type_in,
  input  wire logic       os_sleep_req_in,
  input  wire logic       os_off_req_in,
  input  wire logic       wake_event_in,
  // State report
  output logic      [2:0] sleep_state_out,
  output logic      [1:0] global_state_out,
  output logic            switch_pressed_out,
  // Rail and context control
  output logic            cpu_run_out,
  output logic            cpu_pwr_en_out,
  output logic            dev_pwr_en_out,
  output logic            ram_keep_out,
  output logic            wake_pwr_en_out,
  // Events and intrusion
  output logic            cold_boot_out,
  output logic            resume_out,
  output logic            disk_restore_out,
  output logic            intrusion_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // A debounce window as long as the long press would swallow every press
  if (DEB_CYC < 1 || LONG_CYC <= DEB_CYC) begin : g_bad_counts
    $error("psc_top: need 1 <= DEB_CYC < LONG_CYC");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Map a sleep type to its state; the unused code falls back to RAM sleep
  function automatic psc_state_type psc_sleep_target(input logic [1:0] t);
    case (t)
      PSC_SLP_S1: psc_sleep_target = PSC_ST_S1;
      PSC_SLP_S3: psc_sleep_target = PSC_ST_S3;
      PSC_SLP_S4: psc_sleep_target = PSC_ST_S4;
      default:    psc_sleep_target = PSC_ST_S3;
    endcase
  endfunction : psc_sleep_target

  // Rail word {cpu_run, cpu_pwr, dev_pwr, ram_keep} per state
  function automatic logic [3:0] psc_rails(input psc_state_type s);
    logic [3:0] r;
    r = 4'h0;
    case (s)
      PSC_ST_S0: begin
        r = 4'hf;
      end
      PSC_ST_S1: begin
        // Processor stopped but still powered
        r[PSC_RAIL_CPU_PWR] = 1'b1;
        r[PSC_RAIL_DEV_PWR] = 1'b1;
        r[PSC_RAIL_RAM]     = 1'b1;
      end
      PSC_ST_S3: begin
        r[PSC_RAIL_RAM] = 1'b1;
      end
      PSC_ST_S4: begin
        r = 4'h0;
      end
      PSC_ST_S5: begin
        r = 4'h0;
      end
      default: begin
        r = 4'h0;
      end
    endcase
    psc_rails = r;
  endfunction : psc_rails

  function automatic logic [2:0] psc_scode(input psc_state_type s);
    case (s)
      PSC_ST_S0: psc_scode = PSC_SCODE_S0;
      PSC_ST_S1: psc_scode = PSC_SCODE_S1;
      PSC_ST_S3: psc_scode = PSC_SCODE_S3;
      PSC_ST_S4: psc_scode = PSC_SCODE_S4;
      default:   psc_scode = PSC_SCODE_S5;
    endcase
  endfunction : psc_scode

  function automatic logic [1:0] psc_gcode(input psc_state_type s);
    case (s)
      PSC_ST_S0: psc_gcode = PSC_GCODE_G0;
      PSC_ST_S1: psc_gcode = PSC_GCODE_G1;
      PSC_ST_S3: psc_gcode = PSC_GCODE_G1;
      PSC_ST_S4: psc_gcode = PSC_GCODE_G1;
      default:   psc_gcode = PSC_GCODE_G2;
    endcase
  endfunction : psc_gcode

  ////////////////////////////////////////////////////////////////////////////
  // Switch timing

  psc_sw_if sw_bus ();

  psc_sw_timer #(
    .DEB_CYC  (DEB_CYC),
    .LONG_CYC (LONG_CYC)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .sw_raw_in   (pwr_sw_pressed_in),
    .sw          (sw_bus.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State sequencing

  psc_top_st_type r_q;
  psc_top_st_type r_d;

  always_comb begin
    r_d              = r_q;
    // Event pulses last one enabled cycle
    r_d.cold_boot    = 1'b0;
    r_d.resume       = 1'b0;
    r_d.disk_restore = 1'b0;
    case (r_q.st)
      PSC_ST_S5: begin
        // Nothing survives soft-off, so leaving it is a cold boot
        if (sw_bus.short_pulse || wake_event_in) begin
          r_d.st        = PSC_ST_S0;
          r_d.cold_boot = 1'b1;
        end
      end
      PSC_ST_S0: begin
        // Long press beats every other request: it is the fail-safe path
        if (sw_bus.long_pulse || os_off_req_in) begin
          r_d.st = PSC_ST_S5;
        end else if (sw_bus.short_pulse || os_sleep_req_in) begin
          r_d.st = psc_sleep_target(sleep_type_in);
        end
      end
      PSC_ST_S1, PSC_ST_S3, PSC_ST_S4: begin
        if (sw_bus.long_pulse) begin
          r_d.st = PSC_ST_S5;
        end else if (sw_bus.short_pulse || wake_event_in) begin
          r_d.st     = PSC_ST_S0;
          r_d.resume = 1'b1;
          // Disk sleep holds nothing in memory; firmware must reload it
          r_d.disk_restore = (r_q.st == PSC_ST_S4);
        end
      end
      default: begin
        r_d.st = PSC_ST_S5;
      end
    endcase
    r_d.rails = psc_rails(r_d.st);
    r_d.scode = psc_scode(r_d.st);
    r_d.gcode = psc_gcode(r_d.st);
    // New closure wins over a clear in the same cycle
    if (chassis_sw_closed_in) begin
      r_d.intrusion = 1'b1;
    end else if (intrusion_clr_in) begin
      r_d.intrusion = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r_q.st           <= PSC_ST_S5;
      r_q.rails        <= 4'h0;
      r_q.scode        <= PSC_SCODE_S5;
      r_q.gcode        <= PSC_GCODE_G2;
      r_q.cold_boot    <= 1'b0;
      r_q.resume       <= 1'b0;
      r_q.disk_restore <= 1'b0;
      r_q.intrusion    <= 1'b0;
    end else if (clk_en_in) begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sleep_state_out    = r_q.scode;
  assign global_state_out   = r_q.gcode;
  assign switch_pressed_out = sw_bus.pressed;
  assign cpu_run_out        = r_q.rails[PSC_RAIL_CPU_RUN];
  assign cpu_pwr_en_out     = r_q.rails[PSC_RAIL_CPU_PWR];
  assign dev_pwr_en_out     = r_q.rails[PSC_RAIL_DEV_PWR];
  assign ram_keep_out       = r_q.rails[PSC_RAIL_RAM];
  // Wake logic sits on standby power and is never cut here
  assign wake_pwr_en_out    = 1'b1;
  assign cold_boot_out      = r_q.cold_boot;
  assign resume_out         = r_q.resume;
  assign disk_restore_out   = r_q.disk_restore;
  assign intrusion_out      = r_q.intrusion;

endmodule : psc_top

// [verification/psc_top_props.sv]
// Concurrent checks on the power switch state controller ports
`timescale 1ns/1ps
module psc_top_props
  import psc_pkg::*;
#(
  parameter longint unsigned DEB_CYC  = PSC_DEB_CYC,
  parameter longint unsigned LONG_CYC = PSC_LONG_CYC
) (
  // Watched ports
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       clk_en_in,
  input wire logic       chassis_sw_closed_in,
  input wire logic [2:0] sleep_state_out,
  input wire logic [1:0] global_state_out,
  input wire logic       switch_pressed_out,
  input wire logic       cpu_run_out,
  input wire logic       cpu_pwr_en_out,
  input wire logic       dev_pwr_en_out,
  input wire logic       ram_keep_out,
  input wire logic       wake_pwr_en_out,
  input wire logic       cold_boot_out,
  input wire logic       resume_out,
  input wire logic       disk_restore_out,
  input wire logic       intrusion_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////
  // Hold outlasts any repetition, so it is counted here
  logic [31:0] held_q;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) held_q <= 32'h0;
    else if (clk_en_in) held_q <= switch_pressed_out ? held_q + 32'h1 : 32'h0;
  end
  ////////////////////////////////////////////////////////////
  wake_logic_on_a: assert property (wake_pwr_en_out)
    else $error("wake logic unpowered");
  cpu_run_s0_a: assert property (cpu_run_out == (sleep_state_out == PSC_SCODE_S0))
    else $error("processor runs outside working");
  s3_rails_a: assert property (sleep_state_out == PSC_SCODE_S3 |->
    !cpu_pwr_en_out && !dev_pwr_en_out && ram_keep_out) else $error("bad rails in S3");
  s4_rails_a: assert property (sleep_state_out == PSC_SCODE_S4 |->
    !cpu_pwr_en_out && !dev_pwr_en_out && !ram_keep_out) else $error("bad rails in S4");
  s5_rails_a: assert property (sleep_state_out == PSC_SCODE_S5 |-> global_state_out == PSC_GCODE_G2 &&
    !cpu_pwr_en_out && !dev_pwr_en_out && !ram_keep_out) else $error("bad rails in S5");
  cold_boot_a: assert property (cold_boot_out |->
    sleep_state_out == PSC_SCODE_S0 && $past(sleep_state_out) == PSC_SCODE_S5) else $error("bad cold boot");
  disk_resume_a: assert property (disk_restore_out |->
    resume_out && $past(sleep_state_out) == PSC_SCODE_S4) else $error("bad disk restore");
  resume_wake_a: assert property (resume_out |-> global_state_out == PSC_GCODE_G0 &&
    $past(global_state_out) == PSC_GCODE_G1 ##1 !resume_out) else $error("bad resume");
  intrusion_set_a: assert property (clk_en_in && chassis_sw_closed_in |=> intrusion_out)
    else $error("intrusion missed");
  long_press_off_a: assert property (held_q > LONG_CYC + 3 |-> sleep_state_out == PSC_SCODE_S5)
    else $error("long press did not power off");
  cover property (cold_boot_out);
  cover property (disk_restore_out);
  cover property (held_q > LONG_CYC + 3);
endmodule : psc_top_props

bind psc_top psc_top_props #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) psc_top_props_inst (.*);

// [verification/psc_panel_model.sv]
// Front panel power switch and chassis switch model
`timescale 1ns/1ps
module psc_panel_model (
  // Clock and bench controls
  input  wire logic       core_clk_in,
  input  wire logic       go_in,
  input  wire logic [8:0] hold_in,
  input  wire logic       lid_open_in,
  // Switch contacts and busy flag
  output logic            pwr_sw_pressed_out,
  output logic            chassis_sw_closed_out,
  output logic            busy_out
);
  logic [9:0] cnt_q = 10'h0;
  logic [9:0] top_q = 10'h0;
  // Every press bounces: two cycles made, two open, then the real hold
  always @(posedge core_clk_in) begin
    if (go_in) cnt_q <= {1'b0, hold_in} + 10'h4;
    else if (cnt_q != 10'h0) cnt_q <= cnt_q - 10'h1;
    if (go_in) top_q <= {1'b0, hold_in};
  end
  assign pwr_sw_pressed_out = (cnt_q != 10'h0) && (cnt_q <= top_q || cnt_q > top_q + 10'h2);
  // Removing the cover closes the chassis switch
  assign chassis_sw_closed_out = lid_open_in;
  assign busy_out = cnt_q != 10'h0;
endmodule : psc_panel_model

// [verification/psc_top_bench.sv]
// Self-checking bench for the power switch state controller
`timescale 1ns/1ps
module psc_top_bench;
  import psc_pkg::*;
  // Short counts keep the run brief
  localparam longint unsigned DEB = 4;
  localparam longint unsigned LNG = 64;
  logic core_clk_in = 0, sys_rst_in = 1, clk_en_in = 1, intrusion_clr_in = 0, os_off_req_in = 0;
  logic os_sleep_req_in = 0, wake_event_in = 0, go = 0, lid = 0, pwr_sw_pressed_in, chassis_sw_closed_in, busy;
  logic [1:0] sleep_type_in = 2'h0;
  logic [8:0] hold = 9'h0;
  logic [2:0] sleep_state_out;
  logic [1:0] global_state_out;
  logic switch_pressed_out, cpu_run_out, cpu_pwr_en_out, dev_pwr_en_out, ram_keep_out, wake_pwr_en_out;
  logic cold_boot_out, resume_out, disk_restore_out, intrusion_out;
  int n_fail = 0, tests_run = 0, n_cold = 0, n_res = 0, n_disk = 0, cycles = 0;
  psc_top #(.DEB_CYC(DEB), .LONG_CYC(LNG)) psc_top_inst (.*);
  psc_panel_model psc_panel_model_inst (.core_clk_in(core_clk_in), .go_in(go), .hold_in(hold), .lid_open_in(lid),
    .pwr_sw_pressed_out(pwr_sw_pressed_in), .chassis_sw_closed_out(chassis_sw_closed_in), .busy_out(busy));
  initial forever #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cold_boot_out === 1'b1) n_cold <= n_cold + 1;
    if (resume_out === 1'b1) n_res <= n_res + 1;
    if (disk_restore_out === 1'b1) n_disk <= n_disk + 1;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task ck(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : ck
  task cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc
  // Outputs are looked at on the falling edge, once registers have settled
  task settle;
    @(negedge core_clk_in);
  endtask : settle
  task press(input logic [8:0] n, input bit wait_end);
    @(posedge core_clk_in);
    go <= 1'b1;
    hold <= n;
    @(posedge core_clk_in);
    go <= 1'b0;
    cyc(2);
    for (int i = 0; i < 400 && wait_end && busy; i++) cyc(1);
    if (wait_end) cyc(DEB + 3);
  endtask : press
  // Request codes: 0 sleep, 1 wake, 2 soft-off
  task req(input logic [1:0] k);
    @(posedge core_clk_in);
    wake_event_in   <= (k == 2'h1);
    os_sleep_req_in <= (k == 2'h0);
    os_off_req_in   <= (k == 2'h2);
    @(posedge core_clk_in);
    wake_event_in   <= 1'b0;
    os_sleep_req_in <= 1'b0;
    os_off_req_in   <= 1'b0;
    cyc(1);
  endtask : req
  ////////////////////////////////////////////////////////////
  task t_reset_glitch;
    settle();
    ck({sleep_state_out, global_state_out, ram_keep_out, wake_pwr_en_out}, {PSC_SCODE_S5, PSC_GCODE_G2, 2'h1});
    press(0, 1);
    settle();
    ck(sleep_state_out, PSC_SCODE_S5);
  endtask : t_reset_glitch
  task t_power_on;
    press(20, 1);
    settle();
    ck({sleep_state_out, global_state_out, cpu_run_out}, {PSC_SCODE_S0, PSC_GCODE_G0, 1'b1});
    ck(8'(n_cold), 8'h1);
  endtask : t_power_on
  task t_sleep_types;
    logic [2:0] sc [4];
    sc = '{PSC_SCODE_S1, PSC_SCODE_S3, PSC_SCODE_S4, PSC_SCODE_S3};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      sleep_type_in <= 2'(i);
      req(2'h0);
      settle();
      ck({sleep_state_out, global_state_out}, {sc[i], PSC_GCODE_G1});
      ck({ram_keep_out, cpu_pwr_en_out, dev_pwr_en_out}, {i != 2, i == 0, i == 0});
      req(2'h1);
      settle();
      ck({sleep_state_out, ram_keep_out}, {PSC_SCODE_S0, 1'b1});
    end
    ck(8'(n_res), 8'h4);
    ck(8'(n_disk), 8'h1);
  endtask : t_sleep_types
  task t_button_sleep;
    @(posedge core_clk_in);
    sleep_type_in <= PSC_SLP_S3;
    press(20, 1);
    settle();
    ck({sleep_state_out, global_state_out}, {PSC_SCODE_S3, PSC_GCODE_G1});
    press(20, 1);
    settle();
    ck(sleep_state_out, PSC_SCODE_S0);
    ck(8'(n_res), 8'h5);
  endtask : t_button_sleep
  task t_long_on;
    press(100, 0);
    for (int i = 0; i < 200 && sleep_state_out !== PSC_SCODE_S5; i++) settle();
    ck({busy, global_state_out}, {1'b1, PSC_GCODE_G2});
    press(0, 1);
    settle();
    ck(sleep_state_out, PSC_SCODE_S5);
    ck(8'(n_cold), 8'h1);
  endtask : t_long_on
  task t_long_sleep;
    press(20, 1);
    sleep_type_in <= PSC_SLP_S4;
    req(2'h0);
    settle();
    ck(sleep_state_out, PSC_SCODE_S4);
    press(100, 1);
    settle();
    ck({sleep_state_out, global_state_out}, {PSC_SCODE_S5, PSC_GCODE_G2});
    ck(8'(n_cold), 8'h2);
  endtask : t_long_sleep
  task t_os_off;
    req(2'h0);
    settle();
    ck(sleep_state_out, PSC_SCODE_S5);
    req(2'h1);
    settle();
    ck({sleep_state_out, global_state_out}, {PSC_SCODE_S0, PSC_GCODE_G0});
    ck(8'(n_cold), 8'h3);
    req(2'h2);
    settle();
    ck({sleep_state_out, global_state_out, cpu_pwr_en_out}, {PSC_SCODE_S5, PSC_GCODE_G2, 1'b0});
  endtask : t_os_off
  task t_intrusion;
    settle();
    ck(intrusion_out, 8'h0);
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    lid <= 1'b1;
    req(2'h1);
    settle();
    ck({sleep_state_out, intrusion_out}, {PSC_SCODE_S5, 1'b0});
    @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    cyc(2);
    settle();
    ck(intrusion_out, 8'h1);
    @(posedge core_clk_in);
    intrusion_clr_in <= 1'b1;
    cyc(2);
    settle();
    ck(intrusion_out, 8'h1);
    @(posedge core_clk_in);
    lid <= 1'b0;
    cyc(2);
    settle();
    ck(intrusion_out, 8'h0);
    @(posedge core_clk_in);
    intrusion_clr_in <= 1'b0;
  endtask : t_intrusion
  task t_reset_mid;
    req(2'h1);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    lid <= 1'b1;
    cyc(2);
    sys_rst_in <= 1'b0;
    lid <= 1'b0;
    settle();
    ck({sleep_state_out, global_state_out}, {PSC_SCODE_S5, PSC_GCODE_G2});
    ck({cpu_run_out, intrusion_out}, 8'h0);
    press(20, 1);
    settle();
    ck(sleep_state_out, PSC_SCODE_S0);
  endtask : t_reset_mid
  initial begin
    cyc(16);
    sys_rst_in <= 1'b0;
    cyc(2);
    t_reset_glitch();
    t_power_on();
    t_sleep_types();
    t_button_sleep();
    t_long_on();
    t_long_sleep();
    t_os_off();
    t_intrusion();
    t_reset_mid();
    stop_test();
  end
endmodule : psc_top_bench
